// ---- core/ais_pkg.sv ----
// Constants, types and register map of the auxiliary input supervisor
package ais_pkg;
  // Clock rate and counter sizing
  localparam int CLK_MHZ = 125;
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] ais_cnt_t;

  // Filter and stretch times in microseconds, indexed by code
  localparam int FILT_US [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
  localparam int STR_US [4] = '{0, 100, 1000, 10000};

  // Register indices; byte address is four times the index
  localparam int ADDR_W = 9;
  localparam int IDX_LSB = 2;
  localparam logic [6:0] IDX_HI_THR = 7'h48;
  localparam logic [6:0] IDX_HI_DB = 7'h49;
  localparam logic [6:0] IDX_LO_THR = 7'h4A;
  localparam logic [6:0] IDX_LO_DB = 7'h4B;
  localparam logic [6:0] IDX_DCFG = 7'h4C;
  localparam logic [6:0] IDX_FSEL = 7'h4D;
  localparam logic [6:0] IDX_GCFG = 7'h4E;
  localparam logic [6:0] IDX_STATUS = 7'h4F;
  localparam logic [6:0] IDX_MASK = 7'h50;

  // Field layout
  localparam int GF_W = 3;
  localparam int DB_W = 5;
  localparam int DCFG_GF_LSB = 2;
  localparam int GCFG_POL_BIT = 6;
  localparam int GCFG_EDGE_BIT = 5;
  localparam int GCFG_STR_LSB = 3;

  // Fault type and function codes
  localparam logic [1:0] RS_HI = 2'h0;
  localparam logic [1:0] RS_BOTH = 2'h1;
  localparam logic [1:0] RS_LO = 2'h2;
  localparam logic [1:0] RS_OFF = 2'h3;
  localparam logic [1:0] SEL_DET = 2'h0;
  localparam logic [1:0] SEL_GPI = 2'h1;
  localparam logic [1:0] SEL_GPI_WARN = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // Event bits of status and mask
  localparam int EV_W = 3;
  localparam int EV_FAULT = 0;
  localparam int EV_WARN = 1;
  localparam int EV_EDGE = 2;

  // Reset values
  localparam logic [7:0] RST_HI_THR = 8'hFF;
  localparam logic [7:0] RST_LO_THR = 8'h00;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } ais_avm_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ais_avm_rsp_s;

  typedef struct packed {
    logic flag;
    ais_cnt_t cnt;
  } ais_filt_s;
endpackage : ais_pkg

// ---- core/ais_top.sv ----
// Auxiliary input supervisor: detector, digital input, routing and registers
// Functional notes
// - Flag high limit when level exceeds the 8-bit high threshold.
// - Flag low limit when level falls below the 8-bit low threshold.
// - While high flag set, high threshold is lowered by the 5-bit deadband.
// - While low flag set, low threshold is raised by the 5-bit deadband.
// - Detector filter code selects 0 to 100 us delay.
// - Fault type: high only, both, low only, or detector off.
// - Function choice routes detector or digital faults and warnings, or nothing.
// - Polarity flip inverts the sensed pin level first.
// - Level or edge bit selects level or edge evaluation of the pin.
// - After a rising edge of the polarity-adjusted input, emit a pulse of 0, 100, 1000 or 10000 us.
// - Digital path ignores pulses shorter than its selected glitch time.
`timescale 1ns/1ps
module ais_top #(
  parameter int US_CYCLES = ais_pkg::CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] fifth_aux_level,
  input wire logic fifth_aux_pin,
  input wire ais_pkg::ais_avm_req_s avm_req,
  output ais_pkg::ais_avm_rsp_s avm_rsp,
  output logic high_limit_flag,
  output logic low_limit_flag,
  output logic fault,
  output logic warning,
  output logic irq
);
  import ais_pkg::*;

  typedef struct packed {
    logic [7:0] lvl1;
    logic [7:0] lvl2;
    logic pin1;
    logic pin2;
    logic [7:0] thr_hi;
    logic [DB_W-1:0] db_hi;
    logic [7:0] thr_lo;
    logic [DB_W-1:0] db_lo;
    logic [GF_W-1:0] gf_det;
    logic [1:0] rs;
    logic [1:0] sel;
    logic pol;
    logic edge_mode;
    logic [1:0] str;
    logic [GF_W-1:0] gf_din;
    ais_filt_s hi;
    ais_filt_s lo;
    ais_filt_s din;
    ais_cnt_t str_cnt;
    logic fault_q;
    logic warn_q;
    logic [EV_W-1:0] sts;
    logic [EV_W-1:0] msk;
    logic irq_q;
    logic [7:0] rdata;
    logic wait_q;
  } ais_state_s;

  ais_state_s st;
  ais_state_s nx;

  logic [8:0] hi_m;
  logic [8:0] lo_p;
  logic [7:0] eff_hi;
  logic [7:0] eff_lo;
  logic raw_hi;
  logic raw_lo;
  ais_cnt_t det_lim;
  ais_cnt_t din_lim;
  ais_cnt_t str_lim;
  logic pol_pin;
  logic din_rise;
  logic det_fault;
  logic gp_fault;
  logic req;
  logic wr_go;
  logic [6:0] idx;
  logic [31:0] wd;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  // Filter delay in cycles for a glitch code
  function automatic ais_cnt_t filt_lim(logic [GF_W-1:0] c);
    return ais_cnt_t'(FILT_US[c] * US_CYCLES);
  endfunction : filt_lim

  // Flag follows raw only after lim+1 cycles of steady disagreement
  function automatic ais_filt_s filt_step(ais_filt_s f, logic raw, ais_cnt_t lim);
    ais_filt_s r;
    r = f;
    if (raw == f.flag)
    begin
      r.cnt = '0;
    end
    else if (f.cnt >= lim)
    begin
      r.flag = raw;
      r.cnt = '0;
    end
    else
    begin
      r.cnt = f.cnt + 1'b1;
    end
    return r;
  endfunction : filt_step

  // Outputs straight from state flops
  assign avm_rsp.readdata = {24'h000000, st.rdata};
  assign avm_rsp.waitrequest = st.wait_q;
  assign high_limit_flag = st.hi.flag;
  assign low_limit_flag = st.lo.flag;
  assign fault = st.fault_q;
  assign warning = st.warn_q;
  assign irq = st.irq_q;

  // Next-state logic of the whole block
  always_comb
  begin
    nx = st;
    // Two-flop capture of pin-side inputs; level word assumed slow versus clk
    nx.lvl1 = fifth_aux_level;
    nx.lvl2 = st.lvl1;
    nx.pin1 = fifth_aux_pin;
    nx.pin2 = st.pin1;

    // Effective thresholds with saturating deadband
    hi_m = {1'b0, st.thr_hi} - {4'h0, st.db_hi};
    lo_p = {1'b0, st.thr_lo} + {4'h0, st.db_lo};
    eff_hi = st.thr_hi;
    eff_lo = st.thr_lo;
    if (st.hi.flag)
    begin
      eff_hi = hi_m[8] ? 8'h00 : hi_m[7:0];
    end
    if (st.lo.flag)
    begin
      eff_lo = lo_p[8] ? 8'hFF : lo_p[7:0];
    end
    raw_hi = st.lvl2 > eff_hi;
    raw_lo = st.lvl2 < eff_lo;

    // Detector glitch filtering
    det_lim = filt_lim(st.gf_det);
    nx.hi = filt_step(st.hi, raw_hi, det_lim);
    nx.lo = filt_step(st.lo, raw_lo, det_lim);

    // Fault type selection
    case (st.rs)
      RS_HI: det_fault = st.hi.flag;
      RS_BOTH: det_fault = st.hi.flag | st.lo.flag;
      RS_LO: det_fault = st.lo.flag;
      default: det_fault = 1'b0;
    endcase

    // Digital input path
    pol_pin = st.pin2 ^ st.pol;
    din_lim = filt_lim(st.gf_din);
    nx.din = filt_step(st.din, pol_pin, din_lim);
    din_rise = nx.din.flag & ~st.din.flag;
    str_lim = ais_cnt_t'(STR_US[st.str] * US_CYCLES);
    // Retrigger restarts the pulse; code zero gives no pulse
    if (st.edge_mode && din_rise)
    begin
      nx.str_cnt = str_lim;
    end
    else if (st.str_cnt != '0)
    begin
      nx.str_cnt = st.str_cnt - 1'b1;
    end
    gp_fault = st.edge_mode ? (st.str_cnt != '0) : st.din.flag;

    // Routing to the sequencing side
    nx.fault_q = 1'b0;
    nx.warn_q = 1'b0;
    case (st.sel)
      SEL_DET: nx.fault_q = det_fault;
      SEL_GPI: nx.fault_q = gp_fault;
      SEL_GPI_WARN:
      begin
        nx.fault_q = gp_fault;
        nx.warn_q = det_fault;
      end
      default: nx.fault_q = 1'b0;
    endcase

    // Events for the interrupt status
    ev = '0;
    ev[EV_FAULT] = nx.fault_q & ~st.fault_q;
    ev[EV_WARN] = nx.warn_q & ~st.warn_q;
    ev[EV_EDGE] = din_rise;

    // Bus slave: answer one cycle after the request, commit on release edge
    req = avm_req.read | avm_req.write;
    idx = avm_req.address[IDX_LSB +: 7];
    wd = avm_req.writedata;
    wr_go = avm_req.write & ~st.wait_q;
    nx.wait_q = ~(req & st.wait_q);
    clr = '0;
    if (wr_go)
    begin
      // Only used bits are stored; the rest is dropped
      if (idx == IDX_HI_THR)
        nx.thr_hi = wd[7:0];
      else if (idx == IDX_HI_DB)
        nx.db_hi = wd[DB_W-1:0];
      else if (idx == IDX_LO_THR)
        nx.thr_lo = wd[7:0];
      else if (idx == IDX_LO_DB)
        nx.db_lo = wd[DB_W-1:0];
      else if (idx == IDX_DCFG)
      begin
        nx.gf_det = wd[DCFG_GF_LSB +: GF_W];
        nx.rs = wd[1:0];
      end
      else if (idx == IDX_FSEL)
        nx.sel = wd[1:0];
      else if (idx == IDX_GCFG)
      begin
        nx.pol = wd[GCFG_POL_BIT];
        nx.edge_mode = wd[GCFG_EDGE_BIT];
        nx.str = wd[GCFG_STR_LSB +: 2];
        nx.gf_din = wd[GF_W-1:0];
      end
      else if (idx == IDX_STATUS)
        clr = wd[EV_W-1:0];
      else if (idx == IDX_MASK)
        nx.msk = wd[EV_W-1:0];
    end
    // Set wins over a clear in the same cycle
    nx.sts = (st.sts & ~clr) | ev;
    nx.irq_q = |(st.sts & st.msk);

    // Read data captured while waitrequest is still high
    if (req && st.wait_q)
    begin
      nx.rdata = 8'h00;
      if (idx == IDX_HI_THR)
        nx.rdata = st.thr_hi;
      else if (idx == IDX_HI_DB)
        nx.rdata = {3'h0, st.db_hi};
      else if (idx == IDX_LO_THR)
        nx.rdata = st.thr_lo;
      else if (idx == IDX_LO_DB)
        nx.rdata = {3'h0, st.db_lo};
      else if (idx == IDX_DCFG)
        nx.rdata = {3'h0, st.gf_det, st.rs};
      else if (idx == IDX_FSEL)
        nx.rdata = {6'h00, st.sel};
      else if (idx == IDX_GCFG)
        nx.rdata = {1'b0, st.pol, st.edge_mode, st.str, st.gf_din};
      else if (idx == IDX_STATUS)
        nx.rdata = {5'h00, st.sts};
      else if (idx == IDX_MASK)
        nx.rdata = {5'h00, st.msk};
    end
  end

  // State register; quiet configuration out of reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.thr_hi <= RST_HI_THR;
      st.thr_lo <= RST_LO_THR;
      st.rs <= RS_OFF;
      st.sel <= SEL_NONE;
      st.wait_q <= 1'b1;
    end
    else
    begin
      st <= nx;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Detector, routing, digital input, bus and interrupt checks
  chk_hi_set: assert property (
    (!st.hi.flag && st.lvl2 > st.thr_hi && st.gf_det == 3'h0) |=> st.hi.flag)
    else $error("high flag not set above threshold");
  chk_lo_set: assert property (
    (!st.lo.flag && st.lvl2 < st.thr_lo && st.gf_det == 3'h0) |=> st.lo.flag)
    else $error("low flag not set below threshold");
  chk_hi_band: assert property (
    (st.hi.flag && st.lvl2 <= st.thr_hi && {1'b0, st.lvl2} > hi_m) |=> st.hi.flag)
    else $error("high flag cleared inside deadband");
  chk_lo_band: assert property (
    (st.lo.flag && st.lvl2 >= st.thr_lo && {1'b0, st.lvl2} < lo_p) |=> st.lo.flag)
    else $error("low flag cleared inside deadband");
  chk_det_filter: assert property (
    (st.hi.flag != $past(st.hi.flag)) |-> ($past(st.hi.cnt) >= $past(det_lim)))
    else $error("detector flag moved before filter time");
  chk_type_off: assert property (
    (st.sel == SEL_DET && st.rs == RS_OFF) |=> !st.fault_q)
    else $error("fault while detector off");
  chk_no_func: assert property (
    (st.sel == SEL_NONE) |=> (!st.fault_q && !st.warn_q))
    else $error("output while no function selected");
  chk_warn_route: assert property (
    (st.sel == SEL_GPI_WARN) |=> (st.warn_q == $past(det_fault)))
    else $error("detector warning not routed");
  chk_polarity: assert property (
    (st.gf_din == 3'h0) |=> (st.din.flag == ($past(st.pin2) ^ $past(st.pol))))
    else $error("polarity not applied");
  chk_level_mode: assert property (
    (!st.edge_mode && st.sel == SEL_GPI) |=> (st.fault_q == $past(st.din.flag)))
    else $error("level mode fault mismatch");
  chk_pulse_load: assert property (
    (st.edge_mode && din_rise) |=> (st.str_cnt == $past(str_lim)))
    else $error("pulse length not loaded on edge");
  chk_din_filter: assert property (
    (st.din.flag != $past(st.din.flag)) |-> ($past(st.din.cnt) >= $past(din_lim)))
    else $error("digital input moved before glitch time");
  chk_unused_zero: assert property (
    (!st.wait_q && avm_req.read && $past(idx) == IDX_FSEL) |-> (avm_rsp.readdata[7:2] == 6'h00))
    else $error("unused bits read nonzero");
  chk_sticky_set: assert property (
    (ev != '0) |=> ((st.sts & $past(ev)) == $past(ev)))
    else $error("event lost in status");
  chk_irq_level: assert property (
    (|(st.sts & st.msk)) |=> st.irq_q)
    else $error("interrupt not raised");
endmodule : ais_top

// ---- bench/ais_rail_model.sv ----
// Far-side model: monitored rail level and digital pin
`timescale 1ns/1ps
module ais_rail_model (
  input wire logic clk,
  input wire logic [7:0] level_set,
  input wire logic pin_set,
  output logic [7:0] level,
  output logic pin
);
  logic [7:0] level_r = 8'h60;
  logic pin_r = 1'b0;
  // Source moves only after an edge, so the sampler never sees a half change
  always @(posedge clk)
  begin
    level_r <= level_set;
    pin_r <= pin_set;
  end
  assign level = level_r;
  assign pin = pin_r;
endmodule : ais_rail_model

// ---- bench/test_ais_top.sv ----
// Self-checking bench of the auxiliary input supervisor
`timescale 1ns/1ps
module test_ais_top;
  import ais_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] level_set = 8'h60;
  logic pin_set = 1'b0;
  logic [7:0] lvl_w;
  logic pin_w;
  ais_avm_req_s req = '0;
  ais_avm_rsp_s rsp;
  wire [4:0] outs;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] rst_val [9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};

  // Clock of 8 ns
  always #4 clk = ~clk;

  ais_rail_model u_ais_rail_model (.clk(clk), .level_set(level_set), .pin_set(pin_set), .level(lvl_w), .pin(pin_w));
  // One microsecond per cycle keeps the 10000 us stretch short
  ais_top #(.US_CYCLES(1)) u_ais_top (.clk(clk), .nrst(nrst), .fifth_aux_level(lvl_w), .fifth_aux_pin(pin_w),
    .avm_req(req), .avm_rsp(rsp), .high_limit_flag(outs[0]), .low_limit_flag(outs[1]), .fault(outs[2]),
    .warning(outs[3]), .irq(outs[4]));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int n = 0;
    @(posedge clk);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= {idx, 2'h0};
    req.writedata <= {24'h0, wd};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.waitrequest !== 1'b0 && n < 20);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    chk("waitrequest", 32'h0, {31'h0, rsp.waitrequest});
    if (rsp.waitrequest !== 1'b0)
      tally_and_finish();
  endtask : bus

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk($sformatf("reg %0h", idx), exp, x);
  endtask : rd

  // Outputs: 0 high flag, 1 low flag, 2 fault, 3 warning, 4 irq
  task automatic wait_out(input int sel, input logic v);
    int n = 0;
    while (outs[sel] !== v && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk($sformatf("out%0d", sel), {31'h0, v}, {31'h0, outs[sel]});
    if (outs[sel] !== v)
      tally_and_finish();
  endtask : wait_out

  task automatic stay(input int sel, input logic v, input int cyc);
    repeat (cyc)
    begin
      @(posedge clk);
      chk($sformatf("out%0d", sel), {31'h0, v}, {31'h0, outs[sel]});
    end
  endtask : stay

  task automatic set_lvl(input logic [7:0] v);
    @(posedge clk);
    level_set <= v;
  endtask : set_lvl

  task automatic set_pin(input logic p);
    @(posedge clk);
    pin_set <= p;
  endtask : set_pin

  task automatic pulse_len(input int exp);
    int n = 0;
    wait_out(2, 1'b1);
    // Bound covers the longest stretch code with some margin
    while (outs[2] === 1'b1 && n < 10100)
    begin
      @(posedge clk);
      n++;
    end
    chk("pulse_len", exp, n);
    if (outs[2] !== 1'b0)
      tally_and_finish();
  endtask : pulse_len

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(IDX_HI_THR + 7'(i), {24'h0, rst_val[i]});
    rd(7'h51, 32'h0);
    wr(7'h51, 8'h5A);
    rd(7'h51, 32'h0);
    wr(IDX_HI_DB, 8'hFF);
    rd(IDX_HI_DB, 32'h1F);
    wr(IDX_HI_DB, 8'h04);
    wr(IDX_HI_THR, 8'h80);
    wr(IDX_DCFG, 8'h00);
    wr(IDX_FSEL, 8'h00);
    set_lvl(8'h80);
    stay(0, 1'b0, 8);
    set_lvl(8'h81);
    wait_out(0, 1'b1);
    wait_out(2, 1'b1);
    wr(IDX_MASK, 8'h01);
    wait_out(4, 1'b1);
    rd(IDX_STATUS, 32'h1);
    wr(IDX_STATUS, 8'h01);
    wait_out(4, 1'b0);
    rd(IDX_STATUS, 32'h0);
    set_lvl(8'h7D);
    stay(0, 1'b1, 8);
    set_lvl(8'h7C);
    wait_out(0, 1'b0);
    wait_out(2, 1'b0);
    wr(IDX_LO_THR, 8'h40);
    wr(IDX_LO_DB, 8'h03);
    wr(IDX_DCFG, 8'h02);
    set_lvl(8'h40);
    stay(1, 1'b0, 8);
    set_lvl(8'h3F);
    wait_out(1, 1'b1);
    wait_out(2, 1'b1);
    wait_out(4, 1'b1);
    wr(IDX_MASK, 8'h00);
    wait_out(4, 1'b0);
    wr(IDX_STATUS, 8'h01);
    set_lvl(8'h42);
    stay(1, 1'b1, 8);
    set_lvl(8'h43);
    wait_out(1, 1'b0);
    set_lvl(8'h90);
    wait_out(0, 1'b1);
    stay(2, 1'b0, 8);
    wr(IDX_DCFG, 8'h01);
    wait_out(2, 1'b1);
    wr(IDX_DCFG, 8'h03);
    wait_out(2, 1'b0);
    chk("high flag", 32'h1, {31'h0, outs[0]});
    wr(IDX_DCFG, 8'h01);
    wr(IDX_FSEL, 8'h02);
    wait_out(3, 1'b1);
    wait_out(2, 1'b0);
    wr(IDX_FSEL, 8'h03);
    wait_out(3, 1'b0);
    stay(2, 1'b0, 4);
    set_lvl(8'h60);
    wait_out(0, 1'b0);
    wr(IDX_DCFG, 8'h04);
    wr(IDX_FSEL, 8'h00);
    set_lvl(8'h81);
    repeat (3) @(posedge clk);
    set_lvl(8'h60);
    stay(0, 1'b0, 12);
    set_lvl(8'h81);
    stay(0, 1'b0, 6);
    wait_out(0, 1'b1);
    set_lvl(8'h60);
    wr(IDX_DCFG, 8'h03);
    wr(IDX_FSEL, 8'h01);
    set_pin(1'b1);
    wait_out(2, 1'b1);
    set_pin(1'b0);
    wait_out(2, 1'b0);
    wr(IDX_GCFG, 8'h40);
    wait_out(2, 1'b1);
    wr(IDX_GCFG, 8'h02);
    wait_out(2, 1'b0);
    set_pin(1'b1);
    repeat (4) @(posedge clk);
    set_pin(1'b0);
    stay(2, 1'b0, 15);
    wr(IDX_GCFG, 8'h28);
    set_pin(1'b1);
    pulse_len(100);
    stay(2, 1'b0, 5);
    set_pin(1'b0);
    wr(IDX_GCFG, 8'h20);
    set_pin(1'b1);
    stay(2, 1'b0, 20);
    // Remaining stretch codes: 1000 and 10000 cycles at one cycle per us
    set_pin(1'b0);
    wr(IDX_GCFG, 8'h30);
    set_pin(1'b1);
    pulse_len(1000);
    set_pin(1'b0);
    wr(IDX_GCFG, 8'h38);
    set_pin(1'b1);
    pulse_len(10000);
    tally_and_finish();
  end
endmodule : test_ais_top
